// File: pkg/isd_params.svh
// Purpose: Constants for the instruction decoder and execute timing.
// Assumes: 14-bit instruction word, 8-bit data path, 7-bit file register index.
// Notes:   Definitions only.
`ifndef ISD_PARAMS_SVH
`define ISD_PARAMS_SVH
`define IW_MSB        13
`define GRP_HI        13
`define GRP_LO        12
`define OP4_HI        11
`define OP4_LO        8
`define DEST_BIT      7
`define FIDX_HI       6
`define FIDX_LO       0
`define BPOS_HI       9
`define BPOS_LO       7
`define BOP_HI        11
`define BOP_LO        10
`define K8_HI         7
`define K11_HI        10
`define K_LO          0
`define GOTO_BIT      11
`define LIT_HI        11
`define LIT_LO        8
`define CTL_HI        7
`define CTL_LO        0
`define Q_PER_CYCLE   2'h3
`define RESET_VECTOR  11'h000
`define IRQ_VECTOR    11'h004
`define PORT_IDX      7'h05
`define TIMER_IDX     7'h01
`define STATUS_IDX    7'h03
`define PCL_IDX       7'h02
`define STACK_DEPTH   8
`define OSC_HZ        20000000
`define OSC_PERIOD_NS 50
`endif

// File: pkg/isd_pkg.sv
// Purpose: Types shared by the decoder files.
// Assumes: Constants live in isd_params.svh.
// Notes:   One packed struct, decoded_s, carries decoded fields between stages.
package isd_pkg;
    typedef enum logic [1:0] {
        GRP_BYTE = 2'b00,
        GRP_BIT  = 2'b01,
        GRP_JUMP = 2'b10,
        GRP_LIT  = 2'b11
    } group_e;

    typedef enum logic [4:0] {
        OP_NOP = 5'h00, OP_MOVWF = 5'h01, OP_CLRW = 5'h02, OP_ZERO = 5'h03,
        OP_SUB = 5'h04, OP_DEC = 5'h05, OP_IOR = 5'h06, OP_AND = 5'h07,
        OP_XOR = 5'h08, OP_ADD = 5'h09, OP_MOV = 5'h0a, OP_COM = 5'h0b,
        OP_INC = 5'h0c, OP_DECSZ = 5'h0d, OP_RRC = 5'h0e, OP_RLC = 5'h0f,
        OP_SWAP = 5'h10, OP_INCSZ = 5'h11, OP_BCLR = 5'h12, OP_BSET = 5'h13,
        OP_BTSC = 5'h14, OP_BTSS = 5'h15, OP_CALL = 5'h16, OP_GOTO = 5'h17,
        OP_MOVLW = 5'h18, OP_RETLW = 5'h19, OP_IORLW = 5'h1a, OP_ANDLW = 5'h1b,
        OP_XORLW = 5'h1c, OP_SUBLW = 5'h1d, OP_ADDLW = 5'h1e, OP_CTRL = 5'h1f
    } op_e;

    typedef enum logic [2:0] {
        CT_NONE   = 3'h0,
        CT_RETURN = 3'h1,
        CT_RETFIE = 3'h2,
        CT_SLEEP  = 3'h3,
        CT_CLRWDT = 3'h4
    } ctl_e;

    typedef struct packed {
        group_e     grp;
        op_e        op;
        ctl_e       ctl;
        logic       dest_file;
        logic [6:0] fidx;
        logic [2:0] bpos;
        logic [7:0] k8;
        logic [10:0] k11;
        logic       illegal;
    } decoded_s;
endpackage

// File: rtl/instr_field_decode.sv
// Purpose: Pure combinational split of a 14-bit word into group, operation and operands.
// Assumes: Word is stable for the decode cycle.
// Notes:   Don't-care opcode bits are never compared.
`timescale 1ns/1ns
`include "isd_params.svh"
module instr_field_decode (
    // Instruction word
    input  wire logic [13:0]      word,
    // Decoded result
    output isd_pkg::decoded_s     dec
);
    logic [3:0] op4;
    logic [7:0] ctl8;

    always_comb begin
        op4 = word[`OP4_HI:`OP4_LO];
        ctl8 = word[`CTL_HI:`CTL_LO];
        dec = '0;
        dec.grp = isd_pkg::group_e'(word[`GRP_HI:`GRP_LO]);
        dec.dest_file = word[`DEST_BIT];
        dec.fidx = word[`FIDX_HI:`FIDX_LO];
        dec.bpos = word[`BPOS_HI:`BPOS_LO];
        dec.k8 = word[`K8_HI:`K_LO];
        dec.k11 = word[`K11_HI:`K_LO];
        dec.op = isd_pkg::OP_NOP;
        dec.ctl = isd_pkg::CT_NONE;
        case (dec.grp)
            isd_pkg::GRP_BYTE: begin
                case (op4)
                    4'h0: begin
                        if (word[`DEST_BIT]) begin
                            dec.op = isd_pkg::OP_MOVWF;
                        end else begin
                            // Bits 6:5 are don't-care in the no-operation form.
                            case (ctl8 & 8'h9f)
                                8'h00: dec.ctl = isd_pkg::CT_NONE;
                                8'h08: dec.ctl = isd_pkg::CT_RETURN;
                                8'h09: dec.ctl = isd_pkg::CT_RETFIE;
                                default: begin
                                    if (ctl8 == 8'h63) begin
                                        dec.ctl = isd_pkg::CT_SLEEP;
                                    end else if (ctl8 == 8'h64) begin
                                        dec.ctl = isd_pkg::CT_CLRWDT;
                                    end else begin
                                        dec.illegal = 1'b1;
                                    end
                                end
                            endcase
                            dec.op = isd_pkg::OP_CTRL;
                        end
                    end
                    4'h1: dec.op = word[`DEST_BIT] ? isd_pkg::OP_ZERO : isd_pkg::OP_CLRW;
                    4'h2: dec.op = isd_pkg::OP_SUB;
                    4'h3: dec.op = isd_pkg::OP_DEC;
                    4'h4: dec.op = isd_pkg::OP_IOR;
                    4'h5: dec.op = isd_pkg::OP_AND;
                    4'h6: dec.op = isd_pkg::OP_XOR;
                    4'h7: dec.op = isd_pkg::OP_ADD;
                    4'h8: dec.op = isd_pkg::OP_MOV;
                    4'h9: dec.op = isd_pkg::OP_COM;
                    4'ha: dec.op = isd_pkg::OP_INC;
                    4'hb: dec.op = isd_pkg::OP_DECSZ;
                    4'hc: dec.op = isd_pkg::OP_RRC;
                    4'hd: dec.op = isd_pkg::OP_RLC;
                    4'he: dec.op = isd_pkg::OP_SWAP;
                    default: dec.op = isd_pkg::OP_INCSZ;
                endcase
            end
            isd_pkg::GRP_BIT: begin
                case (word[`BOP_HI:`BOP_LO])
                    2'h0: dec.op = isd_pkg::OP_BCLR;
                    2'h1: dec.op = isd_pkg::OP_BSET;
                    2'h2: dec.op = isd_pkg::OP_BTSC;
                    default: dec.op = isd_pkg::OP_BTSS;
                endcase
            end
            isd_pkg::GRP_JUMP: begin
                dec.op = word[`GOTO_BIT] ? isd_pkg::OP_GOTO : isd_pkg::OP_CALL;
            end
            default: begin
                // Low don't-care bits of the literal sub-opcode are masked.
                casez (word[`LIT_HI:`LIT_LO])
                    4'b00??: dec.op = isd_pkg::OP_MOVLW;
                    4'b01??: dec.op = isd_pkg::OP_RETLW;
                    4'b1000: dec.op = isd_pkg::OP_IORLW;
                    4'b1001: dec.op = isd_pkg::OP_ANDLW;
                    4'b1010: dec.op = isd_pkg::OP_XORLW;
                    4'b110?: dec.op = isd_pkg::OP_SUBLW;
                    4'b111?: dec.op = isd_pkg::OP_ADDLW;
                    default: begin
                        dec.op = isd_pkg::OP_NOP;
                        dec.illegal = 1'b1;
                    end
                endcase
            end
        endcase
    end
endmodule

// File: rtl/instruction_set_decoder.sv
// Purpose: Fetch, decode and execute sequencing for a 14-bit instruction word core.
// Assumes: Program memory answers combinationally; file registers answer combinationally.
// Notes:   Work is done once per instruction cycle of four oscillator periods.
`timescale 1ns/1ns
`include "isd_params.svh"
module instruction_set_decoder (
    // Clock and reset
    input  wire logic         ref_clk,
    input  wire logic         nrst,
    // Program memory
    output logic [10:0]       instruction_pointer,
    input  wire logic [13:0]  prog_word,
    // File register port
    output logic [6:0]        file_idx,
    output logic              file_rd,
    input  wire logic [7:0]   file_rdata,
    output logic              file_wr,
    output logic [7:0]        file_wdata,
    // Port pins and side effects
    input  wire logic [7:0]   port_pins,
    output logic              pin_change_clear,
    input  wire logic         prescaler_on_timer,
    output logic              prescaler_clear,
    // Status and control
    output logic [7:0]        acc,
    output logic              carry,
    output logic              digit_carry,
    output logic              zero,
    output logic              sleep_req,
    output logic              wdt_clear,
    output logic              illegal_op,
    output logic              cycle_strobe
);
    typedef enum logic [1:0] {
        ST_FETCH = 2'b00,
        ST_EXEC  = 2'b01,
        ST_FLUSH = 2'b10
    } state_e;

    state_e                 state_r;
    logic [1:0]             q_r;
    logic [13:0]            ir_r;
    logic [10:0]            ptr_r;
    logic [10:0]            stack_r [0:`STACK_DEPTH-1];
    logic [2:0]             sp_r;
    isd_pkg::decoded_s      dec;
    logic                   q_end;
    logic [7:0]             src;
    logic [7:0]             res;
    logic [8:0]             sum;
    logic [4:0]             nib;
    logic                   res_c;
    logic                   res_dc;
    logic                   set_c;
    logic                   set_dc;
    logic                   set_z;
    logic                   to_acc;
    logic                   to_file;
    logic                   skip;
    logic                   jump;
    logic [10:0]            ptr_nxt;
    logic                   uses_file;
    logic [7:0]             pin_meta_r;
    logic [7:0]             pin_sync_r;

    instr_field_decode u_dec (
        .word (ir_r),
        .dec  (dec)
    );

    assign q_end = (q_r == `Q_PER_CYCLE);

    // One instruction cycle spans four oscillator periods.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            q_r <= 2'h0;
        end else begin
            q_r <= q_r + 2'h1;
        end
    end

    assign cycle_strobe = q_end;
    assign instruction_pointer = ptr_r;
    assign uses_file = (dec.grp == isd_pkg::GRP_BIT) ||
        ((dec.grp == isd_pkg::GRP_BYTE) && (dec.op != isd_pkg::OP_CTRL) &&
         (dec.op != isd_pkg::OP_CLRW));
    assign file_idx = dec.fidx;
    // Read happens even for pure writes such as zeroing a register.
    assign file_rd = (state_r == ST_EXEC) && uses_file;
    // Pins are asynchronous, so two flops sit before any logic sees them.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pin_meta_r <= 8'h00;
            pin_sync_r <= 8'h00;
        end else begin
            pin_meta_r <= port_pins;
            pin_sync_r <= pin_meta_r;
        end
    end

    // Port reads take the pins, so a rewrite reflects external levels.
    assign src = (dec.fidx == `PORT_IDX) ? pin_sync_r : file_rdata;

    always_comb begin
        res = 8'h00;
        sum = 9'h000;
        nib = 5'h00;
        res_c = carry;
        res_dc = digit_carry;
        set_c = 1'b0;
        set_dc = 1'b0;
        set_z = 1'b0;
        to_acc = 1'b0;
        to_file = 1'b0;
        skip = 1'b0;
        jump = 1'b0;
        ptr_nxt = ptr_r + 11'h001;
        case (dec.op)
            isd_pkg::OP_MOVWF: begin res = acc; to_file = 1'b1; end
            isd_pkg::OP_CLRW:  begin res = 8'h00; to_acc = 1'b1; set_z = 1'b1; end
            isd_pkg::OP_ZERO:  begin res = 8'h00; to_file = 1'b1; set_z = 1'b1; end
            isd_pkg::OP_SUB, isd_pkg::OP_ADD, isd_pkg::OP_SUBLW, isd_pkg::OP_ADDLW: begin
                if (dec.op == isd_pkg::OP_SUB) begin
                    sum = {1'b0, src} + {1'b0, ~acc} + 9'h001;
                    nib = {1'b0, src[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;
                end else if (dec.op == isd_pkg::OP_SUBLW) begin
                    sum = {1'b0, dec.k8} + {1'b0, ~acc} + 9'h001;
                    nib = {1'b0, dec.k8[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;
                end else if (dec.op == isd_pkg::OP_ADD) begin
                    sum = {1'b0, src} + {1'b0, acc};
                    nib = {1'b0, src[3:0]} + {1'b0, acc[3:0]};
                end else begin
                    sum = {1'b0, dec.k8} + {1'b0, acc};
                    nib = {1'b0, dec.k8[3:0]} + {1'b0, acc[3:0]};
                end
                res = sum[7:0];
                res_c = sum[8];
                res_dc = nib[4];
                set_c = 1'b1;
                set_dc = 1'b1;
                set_z = 1'b1;
                to_acc = 1'b1;
            end
            isd_pkg::OP_DEC, isd_pkg::OP_DECSZ: begin
                res = src - 8'h01;
                set_z = (dec.op == isd_pkg::OP_DEC);
                skip = (dec.op == isd_pkg::OP_DECSZ) && (res == 8'h00);
                to_acc = 1'b1;
            end
            isd_pkg::OP_INC, isd_pkg::OP_INCSZ: begin
                res = src + 8'h01;
                set_z = (dec.op == isd_pkg::OP_INC);
                skip = (dec.op == isd_pkg::OP_INCSZ) && (res == 8'h00);
                to_acc = 1'b1;
            end
            isd_pkg::OP_IOR:   begin res = src | acc; set_z = 1'b1; to_acc = 1'b1; end
            isd_pkg::OP_AND:   begin res = src & acc; set_z = 1'b1; to_acc = 1'b1; end
            isd_pkg::OP_XOR:   begin res = src ^ acc; set_z = 1'b1; to_acc = 1'b1; end
            isd_pkg::OP_MOV:   begin res = src; set_z = 1'b1; to_acc = 1'b1; end
            isd_pkg::OP_COM:   begin res = ~src; set_z = 1'b1; to_acc = 1'b1; end
            isd_pkg::OP_SWAP:  begin res = {src[3:0], src[7:4]}; to_acc = 1'b1; end
            isd_pkg::OP_RRC: begin
                res = {carry, src[7:1]};
                res_c = src[0];
                set_c = 1'b1;
                to_acc = 1'b1;
            end
            isd_pkg::OP_RLC: begin
                res = {src[6:0], carry};
                res_c = src[7];
                set_c = 1'b1;
                to_acc = 1'b1;
            end
            isd_pkg::OP_BCLR: begin
                res = src & ~(8'h01 << dec.bpos);
                to_file = 1'b1;
            end
            isd_pkg::OP_BSET: begin
                res = src | (8'h01 << dec.bpos);
                to_file = 1'b1;
            end
            isd_pkg::OP_BTSC: skip = ~src[dec.bpos];
            isd_pkg::OP_BTSS: skip = src[dec.bpos];
            isd_pkg::OP_CALL, isd_pkg::OP_GOTO: begin
                jump = 1'b1;
                ptr_nxt = dec.k11;
            end
            isd_pkg::OP_MOVLW: begin res = dec.k8; to_acc = 1'b1; end
            isd_pkg::OP_RETLW: begin
                res = dec.k8;
                to_acc = 1'b1;
                jump = 1'b1;
                ptr_nxt = stack_r[sp_r - 3'h1];
            end
            isd_pkg::OP_IORLW: begin res = dec.k8 | acc; set_z = 1'b1; to_acc = 1'b1; end
            isd_pkg::OP_ANDLW: begin res = dec.k8 & acc; set_z = 1'b1; to_acc = 1'b1; end
            isd_pkg::OP_XORLW: begin res = dec.k8 ^ acc; set_z = 1'b1; to_acc = 1'b1; end
            isd_pkg::OP_CTRL: begin
                // No interrupts here, so the interrupt return acts as a plain return.
                if (dec.ctl == isd_pkg::CT_RETURN || dec.ctl == isd_pkg::CT_RETFIE) begin
                    jump = 1'b1;
                    ptr_nxt = stack_r[sp_r - 3'h1];
                end
            end
            default: res = 8'h00;
        endcase
        // Byte ops honour the target bit; other groups fixed their target above.
        if (dec.grp == isd_pkg::GRP_BYTE && to_acc) begin
            to_file = dec.dest_file;
            to_acc = ~dec.dest_file;
        end
        // A write to the low pointer byte is also a pointer change.
        if (to_file && dec.fidx == `PCL_IDX) begin
            jump = 1'b1;
            ptr_nxt = {ptr_r[10:8], res};
        end
    end

    // Sequencer: fetch at cycle end, execute next cycle, flush on a two-cycle op.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state_r <= ST_FETCH;
            ir_r <= 14'h0000;
            ptr_r <= `RESET_VECTOR;
        end else if (q_end) begin
            case (state_r)
                ST_FETCH: begin
                    ir_r <= prog_word;
                    ptr_r <= ptr_r + 11'h001;
                    state_r <= ST_EXEC;
                end
                ST_EXEC: begin
                    if (jump || skip) begin
                        // Prefetched word is dropped and a no-op fills the slot.
                        ir_r <= 14'h0000;
                        ptr_r <= skip ? ptr_r + 11'h001 : ptr_nxt;
                        state_r <= ST_FLUSH;
                    end else begin
                        ir_r <= prog_word;
                        ptr_r <= ptr_r + 11'h001;
                    end
                end
                ST_FLUSH: begin
                    ir_r <= prog_word;
                    ptr_r <= ptr_r + 11'h001;
                    state_r <= ST_EXEC;
                end
                default: state_r <= ST_FETCH;
            endcase
        end
    end

    // Return stack.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            sp_r <= 3'h0;
        end else if (q_end && state_r == ST_EXEC) begin
            if (dec.op == isd_pkg::OP_CALL) begin
                stack_r[sp_r] <= ptr_r;
                sp_r <= sp_r + 3'h1;
            end else if (dec.op == isd_pkg::OP_RETLW ||
                         (dec.op == isd_pkg::OP_CTRL &&
                          (dec.ctl == isd_pkg::CT_RETURN || dec.ctl == isd_pkg::CT_RETFIE))) begin
                sp_r <= sp_r - 3'h1;
            end
        end
    end

    // Accumulator and status flags.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            acc <= 8'h00;
            carry <= 1'b0;
            digit_carry <= 1'b0;
            zero <= 1'b0;
        end else if (q_end && state_r == ST_EXEC) begin
            if (to_acc) begin
                acc <= res;
            end
            if (set_c) begin
                carry <= res_c;
            end
            if (set_dc) begin
                digit_carry <= res_dc;
            end
            if (set_z) begin
                zero <= (res == 8'h00);
            end
        end
    end

    // File write-back and side effects, one-cycle pulses at cycle end.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            file_wr <= 1'b0;
            file_wdata <= 8'h00;
            pin_change_clear <= 1'b0;
            prescaler_clear <= 1'b0;
            sleep_req <= 1'b0;
            wdt_clear <= 1'b0;
            illegal_op <= 1'b0;
        end else begin
            file_wr <= q_end && state_r == ST_EXEC && to_file;
            file_wdata <= res;
            pin_change_clear <= q_end && state_r == ST_EXEC && uses_file &&
                                dec.fidx == `PORT_IDX;
            prescaler_clear <= q_end && state_r == ST_EXEC && to_file &&
                               dec.fidx == `TIMER_IDX && prescaler_on_timer;
            sleep_req <= q_end && state_r == ST_EXEC && dec.op == isd_pkg::OP_CTRL &&
                         dec.ctl == isd_pkg::CT_SLEEP;
            wdt_clear <= q_end && state_r == ST_EXEC && dec.op == isd_pkg::OP_CTRL &&
                         (dec.ctl == isd_pkg::CT_CLRWDT || dec.ctl == isd_pkg::CT_SLEEP);
            illegal_op <= q_end && state_r == ST_EXEC && dec.illegal;
        end
    end
endmodule

// File: verification/isd_checker.sv
// Purpose: Port-level assertions for the instruction decoder.
// Assumes: One instruction cycle is four ref_clk periods, marked by cycle_strobe.
// Notes:   Only design-driven outputs are judged.
`timescale 1ns/1ns
module isd_checker (
    // Clock and reset
    input wire logic        ref_clk, nrst,
    // Program memory
    input wire logic [10:0] instruction_pointer,
    input wire logic [13:0] prog_word,
    // File register port
    input wire logic [6:0]  file_idx,
    input wire logic        file_rd, file_wr,
    input wire logic [7:0]  file_rdata, file_wdata,
    // Port pins and side effects
    input wire logic [7:0]  port_pins,
    input wire logic        pin_change_clear, prescaler_on_timer, prescaler_clear,
    // Status and control
    input wire logic [7:0]  acc,
    input wire logic        carry, digit_carry, zero, sleep_req, wdt_clear, illegal_op,
    input wire logic        cycle_strobe
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    chk_strobe_period: assert property (cycle_strobe |=> !cycle_strobe [*3] ##1 cycle_strobe)
        else $error("cycle strobe not every fourth clock");
    chk_pointer_hold: assert property (!cycle_strobe |=> $stable(instruction_pointer))
        else $error("pointer moved inside a cycle");
    chk_result_hold: assert property (!cycle_strobe |=> $stable({acc, carry, zero}))
        else $error("result changed inside a cycle");
    chk_read_first: assert property (file_wr |-> $past(cycle_strobe) && $past(file_rd))
        else $error("file write without a read in its cycle");
    chk_write_once: assert property (file_wr |=> !file_wr [*3])
        else $error("more than one write per cycle");
    chk_read_level: assert property (file_rd && !cycle_strobe |=> file_rd)
        else $error("file read dropped mid cycle");
    chk_port_clear: assert property (pin_change_clear |-> $past(file_idx) == 7'h05)
        else $error("pin change clear without port access");
    chk_timer_clear: assert property (prescaler_clear |->
        file_wr && $past(file_idx) == 7'h01 && $past(prescaler_on_timer))
        else $error("prescaler clear without timer write");
endmodule
bind instruction_set_decoder isd_checker u_chk (.*);

// File: verification/prog_rom.sv
// Purpose: Program memory model answering the fetch address combinationally.
// Assumes: The bench fills the sixteen-word image while reset is held.
// Notes:   Addresses past the image read as a branch to zero.
`timescale 1ns/1ns
module prog_rom (
    // Fetch port
    input wire logic [10:0] instruction_pointer,
    output logic [13:0]     prog_word
);
    logic [13:0] mem [0:15];
    assign prog_word = (instruction_pointer < 11'h010) ? mem[instruction_pointer[3:0]] : 14'h2800;
endmodule

// File: verification/test_instruction_set_decoder.sv
// Purpose: Self-checking bench running a short program per random seed draw.
// Assumes: Write data is captured whenever file_wr is high.
// Notes:   Each pass resets the core, so a mid-run reset is exercised too.
`timescale 1ns/1ns
`define CHK(nm, e, g) \
    n_tests++; \
    if ((g) !== (e)) begin \
        fails++; \
        $display("wrong value %s expected %h seen %h", nm, e, g); \
    end
module test_instruction_set_decoder;
    logic        ref_clk = 1'b0, nrst = 1'b0, pot = 1'b0, file_wr, pcc, psc, carry, zero;
    logic        slp, wdc, ill, dcy;
    logic [7:0]  rdata = 8'h00, pins = 8'h00, acc, wdata, k, rd, pn;
    logic [2:0]  b;
    logic [10:0] ptr;
    logic [13:0] word;
    logic [7:0]  wq [$];
    int          seed = 33468, fails = 0, n_tests = 0, pcc_n, psc_n, sl_n, wd_n, il_n;
    always #25 ref_clk = ~ref_clk;
    prog_rom u_rom (.instruction_pointer(ptr), .prog_word(word));
    instruction_set_decoder dut (.ref_clk(ref_clk), .nrst(nrst), .instruction_pointer(ptr),
        .prog_word(word), .file_idx(), .file_rd(), .file_rdata(rdata), .file_wr(file_wr),
        .file_wdata(wdata), .port_pins(pins), .pin_change_clear(pcc),
        .prescaler_on_timer(pot), .prescaler_clear(psc), .acc(acc), .carry(carry),
        .digit_carry(dcy), .zero(zero), .sleep_req(slp), .wdt_clear(wdc), .illegal_op(ill),
        .cycle_strobe());
    // Don't-care bit 8 is set to one in the first load to show it is ignored.
    function automatic logic [13:0] prog(int i);
        case (i)
            0: prog = 14'h3100 | k;
            1: prog = 14'h00a0;
            2: prog = 14'h0081;
            3: prog = 14'h0185;
            4: prog = 14'h0885;
            5: prog = 14'h0d20;
            6: prog = 14'h1820 | {b, 7'h00};
            7: prog = 14'h3011;
            8: prog = 14'h3801;
            9: prog = 14'h0063;
            10: prog = 14'h0064;
            11: prog = 14'h3b00;
            default: prog = 14'h280c;
        endcase
    endfunction
    function automatic logic [7:0] exp_acc();
        exp_acc = rd[b] ? 8'h11 : ({rd[6:0], 1'b0} | 8'h01);
    endfunction
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    always @(posedge ref_clk) begin
        if (file_wr === 1'b1) wq.push_back(wdata);
        if (pcc === 1'b1) pcc_n++;
        if (psc === 1'b1) psc_n++;
        if (slp === 1'b1) sl_n++;
        if (wdc === 1'b1) wd_n++;
        if (ill === 1'b1) il_n++;
    end
    initial begin
        #400000;
        fails++;
        final_report();
    end
    initial begin
        for (int it = 0; it < 8; it++) begin
            k = 8'($random(seed));
            rd = (it == 0) ? 8'hff : (it == 1) ? 8'h00 : 8'($random(seed));
            b = (it == 0) ? 3'h7 : (it == 1) ? 3'h0 : 3'($random(seed));
            pn = 8'($random(seed));
            @(posedge ref_clk);
            nrst <= 1'b0;
            rdata <= rd;
            pins <= pn;
            pot <= it[0];
            // The image changes only at a reset edge, so no half-loaded word runs.
            for (int i = 0; i < 16; i++) u_rom.mem[i] = prog(i);
            repeat (5) @(posedge ref_clk);
            #1;
            `CHK("reset acc", 8'h00, acc)
            `CHK("reset pointer", 11'h000, ptr)
            wq.delete();
            pcc_n = 0;
            psc_n = 0;
            sl_n = 0;
            wd_n = 0;
            il_n = 0;
            @(posedge ref_clk) nrst <= 1'b1;
            for (int n = 0; n < 300 && ptr !== 11'h00c; n++) @(posedge ref_clk);
            `CHK("end reached", 11'h00c, ptr)
            repeat (12) @(posedge ref_clk);
            #1;
            `CHK("write count", 4, wq.size())
            `CHK("write literal", k, wq[0])
            `CHK("write timer", k, wq[1])
            `CHK("write cleared port", 8'h00, wq[2])
            `CHK("write port pins", pn, wq[3])
            `CHK("pin change clears", 2, pcc_n)
            `CHK("prescaler clears", int'(it[0]), psc_n)
            `CHK("acc", exp_acc(), acc)
            `CHK("carry", rd[7], carry)
            `CHK("zero", 1'b0, zero)
            `CHK("sleep requests", 1, sl_n)
            `CHK("watchdog clears", 2, wd_n)
            `CHK("illegal words", 1, il_n)
            `CHK("digit carry", 1'b0, dcy)
            $display("test %0d done", it);
        end
        final_report();
    end
endmodule
